// ==== sac_pkg.sv ====
// package: constants for the successive-approximation converter control
package sac_pkg;
  localparam int    SAC_WIDTH         = 16;
  localparam int    SAC_BYTE          = 8;
  localparam int    SAC_CLK_MHZ       = 100;
  // internal bit-trial step period, one decision per step
  localparam int    SAC_STEP_NS       = 400;
  localparam int    SAC_STEP_CYC      = (SAC_STEP_NS * SAC_CLK_MHZ) / 1000;
  localparam int    SAC_FIFO_DEPTH    = 16;
  localparam logic [15:0] SAC_RESULT_RST = 16'h0000;
  typedef enum logic [1:0] {SAC_IDLE, SAC_TRIAL, SAC_LATCH} sac_state_e;
endpackage : sac_pkg

// ==== sac_fifo.sv ====
// file: small synchronous fifo for finished conversion results
`timescale 1ns/100ps
module sac_fifo
  import sac_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)(
  input  wire logic             clk_sys_i,   // system clock
  input  wire logic             sys_rst_i,   // async reset, high
  input  wire logic [WIDTH-1:0] in_data_i,   // write data
  input  wire logic             in_valid_i,  // write request
  output logic                  in_ready_o,  // space available
  output logic      [WIDTH-1:0] out_data_o,  // read data
  output logic                  out_valid_o, // data available
  input  wire logic             out_ready_i  // read accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                            (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              empty = (wr_ptr == rd_ptr);
  wire              push  = in_valid_i && !full;
  wire              pop   = out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data_i;
  end
endmodule : sac_fifo

// ==== sac_ctrl.sv ====
// file: conversion control, bit trial and three-state output port
// Operation
// - lanes are undriven while chip select high or read/convert low
// - byte swap low: result msb on top lane, lsb on lane zero
// - byte swap high: the two result bytes exchange lanes
// - chip select low, read/convert falling starts hold and conversion
// - chip select low, read/convert rising enables the output drivers
// - chip select and read/convert combine as OR of low-active inputs
// - read/convert low, chip select falling starts a conversion
// - read/convert high, chip select falling enables the drivers
// - busy output is low for the whole conversion, high otherwise
// - new result is in output latches when busy rises
// - start conditions are ignored while a conversion runs
// - trial register is cleared at conversion start
// - sixteen decisions are made msb first down to lsb
// - completed trial word is copied into the output latches
// - unipolar result is straight binary, bipolar is two's complement
`timescale 1ns/100ps
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int  WIDTH    = SAC_WIDTH,
  parameter int  STEP_CYC = SAC_STEP_CYC,
  parameter bit  BIPOLAR  = 1'b0
)(
  input  wire logic             clk_sys_i,      // system clock
  input  wire logic             sys_rst_i,      // async reset, high
  input  wire logic             chip_sel_n_i,   // chip select, low active
  input  wire logic             read_conv_i,    // high read, low convert
  input  wire logic             byte_swap_i,    // byte swap select
  input  wire logic             comp_above_i,   // comparator: input above trial
  output logic                  busy_n_o,       // low while converting
  output logic      [WIDTH-1:0] data_out_lanes_o, // port lanes
  output logic      [WIDTH-1:0] data_out_lanes_oe_o, // lane enables
  output logic      [WIDTH-1:0] trial_word_o,   // trial word to the dac
  output logic      [WIDTH-1:0] fifo_data_o,    // buffered results
  output logic                  fifo_valid_o,   // buffered result ready
  input  wire logic             fifo_ready_i,   // consumer takes result
  output logic                  fifo_drop_o     // result lost, fifo full
);
  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers {swap, read/convert, select}; first stage read only
  // by the second; reset to the idle pin levels so no false edge follows
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pin_meta <= 3'h3;
      pin_sync <= 3'h3;
    end
    else
    begin
      pin_meta <= {byte_swap_i, read_conv_i, chip_sel_n_i};
      pin_sync <= pin_meta;
    end
  end
  wire  cs_d   = pin_sync[0];
  wire  rc_d   = pin_sync[1];
  wire  swap_s = pin_sync[2];
  // comparator is synced too, so a step must last at least three cycles
  logic cs_prev, rc_prev, cmp_m, cmp_s;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cs_prev <= 1'b1;
      rc_prev <= 1'b1;
      cmp_m   <= 1'b0;
      cmp_s   <= 1'b0;
    end
    else
    begin
      cs_prev <= cs_d;
      rc_prev <= rc_d;
      cmp_m   <= comp_above_i;
      cmp_s   <= cmp_m;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // decoded control: internal enable is the OR of the low-active inputs
  wire gate_n     = cs_d | ~rc_d;
  wire start_rc   = !cs_d && rc_prev && !rc_d;
  wire start_cs   = !rc_d && cs_prev && !cs_d;
  wire start_req  = start_rc || start_cs;
  wire drive_en   = !gate_n;

  //////////////////////////////////////////////////////////////////////////
  // bit-trial sequencer
  sac_state_e       state, next_state;
  logic [WIDTH-1:0] bit_trial_register;
  logic [WIDTH-1:0] trial_bit;
  logic [WIDTH-1:0] result;
  logic [15:0]      step_cnt;
  wire              step_en = (step_cnt == 16'(STEP_CYC - 1));
  wire              idle    = (state == SAC_IDLE);
  wire              last    = trial_bit[0];

  always_comb
  begin
    next_state = state;
    unique case (state)
      SAC_IDLE:  if (start_req) next_state = SAC_TRIAL;
      SAC_TRIAL: if (step_en && last) next_state = SAC_LATCH;
      SAC_LATCH: next_state = SAC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state <= SAC_IDLE;
    else
      state <= next_state;
  end

  // step timer from the internal clock
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      step_cnt <= '0;
    else if (state != SAC_TRIAL || step_en)
      step_cnt <= '0;
    else
      step_cnt <= step_cnt + 16'h0001;
  end

  // trial word: clear at start, set msb, keep or drop each bit
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bit_trial_register <= '0;
      trial_bit          <= '0;
    end
    else if (idle && start_req)
    begin
      bit_trial_register <= {1'b1, {(WIDTH-1){1'b0}}};
      trial_bit          <= {1'b1, {(WIDTH-1){1'b0}}};
    end
    else if (state == SAC_TRIAL && step_en)
    begin
      // drop the trial bit if the comparator says the word overshoots
      if (!cmp_s)
        bit_trial_register <= (bit_trial_register & ~trial_bit) |
                              (trial_bit >> 1);
      else
        bit_trial_register <= bit_trial_register | (trial_bit >> 1);
      trial_bit <= trial_bit >> 1;
    end
  end

  // output latches hold the last result until the next one lands
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      result <= SAC_RESULT_RST;
    else if (state == SAC_LATCH)
      result <= bit_trial_register;
  end

  // bipolar variant flips the msb so mid-scale reads as zero
  wire [WIDTH-1:0] coded = BIPOLAR ?
                   {~result[WIDTH-1], result[WIDTH-2:0]} : result;
  wire [WIDTH-1:0] lanes = swap_s ?
                   {coded[SAC_BYTE-1:0], coded[WIDTH-1:SAC_BYTE]}
                 : coded;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      busy_n_o            <= 1'b1;
      data_out_lanes_o    <= '0;
      data_out_lanes_oe_o <= '0;
    end
    else
    begin
      // busy rises at the same edge that loads the output latches
      busy_n_o            <= (next_state == SAC_IDLE);
      data_out_lanes_o    <= lanes;
      data_out_lanes_oe_o <= {WIDTH{drive_en}};
    end
  end
  assign trial_word_o = bit_trial_register;

  //////////////////////////////////////////////////////////////////////////
  // result fifo: a full fifo drops the new word and flags it
  logic push_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      push_q <= 1'b0;
    else
      push_q <= (state == SAC_LATCH);
  end
  logic fifo_in_ready;
  sac_fifo #(.WIDTH(WIDTH), .DEPTH(SAC_FIFO_DEPTH)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (coded),
    .in_valid_i  (push_q),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data_o),
    .out_valid_o (fifo_valid_o),
    .out_ready_i (fifo_ready_i)
  );
  assign fifo_drop_o = push_q && !fifo_in_ready;

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_lanes_hiz: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $past(gate_n) |-> data_out_lanes_oe_o == '0)
    else $error("lanes driven while gated");
  a_lanes_order: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !$past(swap_s) |-> data_out_lanes_o == $past(coded))
    else $error("lane order wrong");
  a_lanes_swap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $past(swap_s) |-> data_out_lanes_o[7:0] == $past(coded[15:8]))
    else $error("byte swap wrong");
  a_start_conv: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    idle && start_req |=> state == SAC_TRIAL ##1 !busy_n_o)
    else $error("start not taken");
  a_drive_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    drive_en |=> data_out_lanes_oe_o == '1)
    else $error("read not enabled");
  a_busy_run: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state == SAC_TRIAL && $past(state) == SAC_TRIAL |-> !busy_n_o)
    else $error("busy high during conversion");
  a_latch_busy: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(busy_n_o) |-> result == $past(bit_trial_register))
    else $error("result not latched at busy rise");
  a_no_restart: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state == SAC_TRIAL && start_req && !step_en |=> state == SAC_TRIAL)
    else $error("conversion restarted");
  a_hold_prev: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state != SAC_LATCH |=> $stable(result))
    else $error("result changed outside latch");
  c_conv: cover property (@(posedge clk_sys_i) $rose(busy_n_o));
  c_read: cover property (@(posedge clk_sys_i) drive_en && swap_s);
  c_full: cover property (@(posedge clk_sys_i) fifo_drop_o);
endmodule : sac_ctrl

// ==== sac_far_model.sv ====
// file: far-side model, comparator on a held input and resolved port wires
`timescale 1ns/100ps
module sac_far_model
  import sac_pkg::*;
(
  input  wire logic                 clk_sys_i,    // system clock
  input  wire logic [SAC_WIDTH-1:0] target_i,     // held input as a code
  input  wire logic [SAC_WIDTH-1:0] trial_i,      // trial word from dac side
  input  wire logic [SAC_WIDTH-1:0] lanes_i,      // lane values
  input  wire logic [SAC_WIDTH-1:0] lanes_oe_i,   // lane enables
  output logic                      comp_above_o, // comparator decision
  output logic      [SAC_WIDTH-1:0] bus_o         // resolved port wires
);
  logic [SAC_WIDTH-1:0] last_bus;
  // ideal comparator: the trial bit stays while the input is at or above it
  assign comp_above_o = (target_i >= trial_i);
  // a released lane floats; show its inverse so stale data never passes
  assign bus_o = (lanes_oe_i & lanes_i) | (~lanes_oe_i & ~last_bus);
  always_ff @(posedge clk_sys_i)
  begin
    last_bus <= (lanes_oe_i & lanes_i) | (~lanes_oe_i & last_bus);
  end
endmodule : sac_far_model

// ==== sac_ctrl_test.sv ====
// file: self-checking testbench for the converter control block
`timescale 1ns/100ps
module sac_ctrl_test
  import sac_pkg::*;
;
  localparam int W = SAC_WIDTH;
  logic         clk_sys_i, sys_rst_i, chip_sel_n_i, read_conv_i;
  logic         byte_swap_i, fifo_ready_i, comp_above, busy_n;
  logic         fifo_valid, fifo_drop, drop_seen;
  logic [W-1:0] lanes, lanes_oe, trial, fifo_data, bus, target;
  logic [W-1:0] exp_q[$];
  int           errors, compares;

  ////////////////////////////////////////////////////////////////////////////
  sac_ctrl #(.STEP_CYC(4)) DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .chip_sel_n_i(chip_sel_n_i), .read_conv_i(read_conv_i),
    .byte_swap_i(byte_swap_i), .comp_above_i(comp_above),
    .busy_n_o(busy_n), .data_out_lanes_o(lanes),
    .data_out_lanes_oe_o(lanes_oe), .trial_word_o(trial),
    .fifo_data_o(fifo_data), .fifo_valid_o(fifo_valid),
    .fifo_ready_i(fifo_ready_i), .fifo_drop_o(fifo_drop));
  sac_far_model far (
    .clk_sys_i(clk_sys_i), .target_i(target), .trial_i(trial),
    .lanes_i(lanes), .lanes_oe_i(lanes_oe), .comp_above_o(comp_above),
    .bus_o(bus));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // the drop flag is a one-cycle pulse, so keep it sticky for the checks
  always @(posedge clk_sys_i)
    if (fifo_drop === 1'b1)
      drop_seen <= 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_n !== lvl && n < 400)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 400)
    begin
      errors++;
      print_verdict();
    end
  endtask : wait_busy

  // chip select stays low; read/convert alone starts the conversion
  task convert(input logic [W-1:0] tgt);
    target = tgt;
    exp_q.push_back(tgt);
    read_conv_i = 1'b0;
    wait_busy(1'b0);
    check(lanes_oe, 16'h0000);
    repeat (4) @(negedge clk_sys_i);
    read_conv_i = 1'b1;
    wait_busy(1'b1);
    repeat (200) @(negedge clk_sys_i);
  endtask : convert

  task read_port(input logic swap, input logic [W-1:0] exp);
    byte_swap_i = swap;
    repeat (5) @(negedge clk_sys_i);
    check(lanes_oe, 16'hFFFF);
    check(bus, swap ? {exp[7:0], exp[15:8]} : exp);
  endtask : read_port

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    errors = 0;
    compares = 0;
    drop_seen = 1'b0;
    target = 16'h0000;
    sys_rst_i = 1'b1;
    chip_sel_n_i = 1'b0;
    read_conv_i = 1'b1;
    byte_swap_i = 1'b0;
    fifo_ready_i = 1'b0;
    repeat (12) @(negedge clk_sys_i);
    check(16'(busy_n), 16'h0001);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    convert(16'hA5C3);
    read_port(1'b0, 16'hA5C3);
    read_port(1'b1, 16'hA5C3);
    read_port(1'b0, 16'hA5C3);
    // a second start while running must not restart the conversion
    target = 16'h1234;
    exp_q.push_back(target);
    read_conv_i = 1'b0;
    wait_busy(1'b0);
    repeat (4) @(negedge clk_sys_i);
    read_conv_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    read_conv_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    read_conv_i = 1'b1;
    wait_busy(1'b1);
    repeat (20) @(negedge clk_sys_i);
    check(16'(busy_n), 16'h0001);
    read_port(1'b0, 16'h1234);
    // chip select high blocks both start and read
    chip_sel_n_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    check(lanes_oe, 16'h0000);
    read_conv_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    check(16'(busy_n), 16'h0001);
    // chip-select-controlled conversion, read/convert already low
    target = 16'h8001;
    exp_q.push_back(target);
    chip_sel_n_i = 1'b0;
    wait_busy(1'b0);
    repeat (4) @(negedge clk_sys_i);
    chip_sel_n_i = 1'b1;
    read_conv_i = 1'b1;
    wait_busy(1'b1);
    repeat (200) @(negedge clk_sys_i);
    check(lanes_oe, 16'h0000);
    chip_sel_n_i = 1'b0;
    read_port(1'b0, 16'h8001);
    // fill the result buffer to its depth, then one more is dropped
    for (int k = 0; k < SAC_FIFO_DEPTH - 3; k++)
      convert(16'h0F0F ^ (16'(k) * 16'h1111));
    check(16'(drop_seen), 16'h0000);
    convert(16'hFFFF);
    void'(exp_q.pop_back());
    check(16'(drop_seen), 16'h0001);
    for (int k = 0; k < SAC_FIFO_DEPTH; k++)
    begin
      check(16'(fifo_valid), 16'h0001);
      check(fifo_data, exp_q.pop_front());
      fifo_ready_i = 1'b1;
      @(negedge clk_sys_i);
      fifo_ready_i = 1'b0;
      @(negedge clk_sys_i);
    end
    check(16'(fifo_valid), 16'h0000);
    print_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    errors++;
    print_verdict();
  end
endmodule : sac_ctrl_test
